// ### icdac_pkg.sv
package icdac_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus figures
   localparam int unsigned SYS_CLK_HZ      = 200_000_000;
   localparam int unsigned SCL_MAX_HZ      = 400_000;
   localparam int unsigned SCL_MIN_PERIOD  = SYS_CLK_HZ / SCL_MAX_HZ;

   ////////////////////////////////////////////////////////////////////////////
   // Addressing
   localparam logic [4:0] SLAVE_ADDR_TOP   = 5'h03;
   localparam int         ADDR_TOP_MSB     = 7;
   localparam int         ADDR_TOP_LSB     = 3;
   localparam int         DIR_BIT          = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Byte framing
   localparam logic [3:0] BIT_CNT_ZERO     = 4'h0;
   localparam logic [3:0] BIT_CNT_ONE      = 4'h1;
   localparam logic [3:0] BIT_CNT_BYTE     = 4'h8;
   localparam logic [3:0] BIT_CNT_ACK      = 4'h9;
   localparam logic [1:0] BYTE_ADDR        = 2'h0;
   localparam logic [1:0] BYTE_HIGH        = 2'h1;
   localparam logic [1:0] BYTE_LOW         = 2'h2;
   localparam logic [1:0] BYTE_ONE         = 2'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Input word layout and reset values
   localparam int          WORD_W          = 16;
   localparam int          CODE_W          = 10;
   localparam int          INPUT_WORD_TOP_BIT = 15;
   localparam int          DAC_CODE_MSB    = 13;
   localparam int          DAC_CODE_LSB    = 4;
   localparam logic [15:0] INPUT_WORD_RST  = 16'h0000;
   localparam logic [7:0]  BYTE_RST        = 8'h00;

   typedef struct packed {
      logic              power_down;
      logic [CODE_W-1:0] code;
   } icdac_dac_t;

   localparam icdac_dac_t DAC_RST = '{power_down: 1'b0, code: 10'h000};

   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_ADDR   = 5'b00010,
      ST_RECV   = 5'b00100,
      ST_SEND   = 5'b01000,
      ST_IGNORE = 5'b10000
   } icdac_state_t;

endpackage : icdac_pkg

// ### icdac_top.sv
// How it works
// - Accepts bus clock up to 400 kHz
// - Completed read clears the input word
// - Start detected, eight bits shifted in
// - First byte: address plus direction bit
// - Answers 0001100, low two bits ignored
// - Address ack held low through ninth clock
// - SDA change with SCL high: start/stop
// - Acknowledge after matched address and both written data bytes
// - At most two data bytes per transfer
// - Second data byte always acknowledged
// - High byte first, MSB first, 16 bits
// - Full write copies word to converter
// - Word top bit requests soft power-down
// - Bits 13 to 4 carry the code
// - Read returns word in write order
// - Power-down pin forces off asynchronously
`timescale 1ns/1ps

module icdac_top (
   input  wire logic                        SYS_CLK,
   input  wire logic                        RESETN,
   input  wire logic                        SCL_CLK,
   input  wire logic                        SDA_IN,
   output logic                             SDA_OUT,
   output logic                             SDA_OE,
   input  wire logic                        POWER_DOWN_CONTROL_N,
   output logic [icdac_pkg::CODE_W-1:0]     DAC_CODE,
   output logic                             DAC_POWER_DOWN,
   output logic [icdac_pkg::WORD_W-1:0]     INPUT_WORD
);

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: bits shift in on each rising bus clock
   // The system side reads this byte only while the synchronised bus
   // clock is low, when no rising edge can move it
   logic [7:0] link_shift_reg;
   logic [7:0] link_shift_next;

   always_comb begin
      link_shift_next = {link_shift_reg[6:0], SDA_IN};
   end

   always_ff @(posedge SCL_CLK) begin
      link_shift_reg <= link_shift_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line synchronisers, system domain
   logic scl_meta_reg;
   logic scl_sync_reg;
   logic scl_prev_reg;
   logic sda_meta_reg;
   logic sda_sync_reg;
   logic sda_prev_reg;
   logic scl_meta_next;
   logic scl_sync_next;
   logic scl_prev_next;
   logic sda_meta_next;
   logic sda_sync_next;
   logic sda_prev_next;

   always_comb begin
      scl_meta_next = SCL_CLK;
      scl_sync_next = scl_meta_reg;
      scl_prev_next = scl_sync_reg;
      sda_meta_next = SDA_IN;
      sda_sync_next = sda_meta_reg;
      sda_prev_next = sda_sync_reg;
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_meta_reg <= scl_meta_next;
         scl_sync_reg <= scl_sync_next;
         scl_prev_reg <= scl_prev_next;
         sda_meta_reg <= sda_meta_next;
         sda_sync_reg <= sda_sync_next;
         sda_prev_reg <= sda_prev_next;
      end
   end

   // Oversampling at many clocks per bus bit covers the fastest bus rate
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   always_comb begin
      scl_rise  = scl_sync_reg & ~scl_prev_reg;
      scl_fall  = ~scl_sync_reg & scl_prev_reg;
      bus_start = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
      bus_stop  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer sequencer
   icdac_pkg::icdac_state_t state_reg;
   icdac_pkg::icdac_state_t state_next;
   logic [3:0]                       bit_cnt_reg;
   logic [3:0]                       bit_cnt_next;
   logic [1:0]                       byte_cnt_reg;
   logic [1:0]                       byte_cnt_next;
   logic                             rw_reg;
   logic                             rw_next;
   logic [7:0]                       hold_reg;
   logic [7:0]                       hold_next;
   logic [7:0]                       tx_reg;
   logic [7:0]                       tx_next;
   logic                             sda_oe_reg;
   logic                             sda_oe_next;
   logic [icdac_pkg::WORD_W-1:0]     input_word_reg;
   logic [icdac_pkg::WORD_W-1:0]     input_word_next;
   icdac_pkg::icdac_dac_t            dac_reg;
   icdac_pkg::icdac_dac_t            dac_next;
   logic                             pd_reg;
   logic                             pd_next;

   function automatic icdac_pkg::icdac_dac_t word_to_dac(
      input logic [icdac_pkg::WORD_W-1:0] word
   );
      icdac_pkg::icdac_dac_t d;
      d.power_down = word[icdac_pkg::INPUT_WORD_TOP_BIT];
      d.code       = word[icdac_pkg::DAC_CODE_MSB:icdac_pkg::DAC_CODE_LSB];
      return d;
   endfunction : word_to_dac

   function automatic logic [7:0] word_byte(
      input logic [icdac_pkg::WORD_W-1:0] word,
      input logic [1:0]                   idx
   );
      return (idx == icdac_pkg::BYTE_HIGH) ? word[15:8] : word[7:0];
   endfunction : word_byte

   // The input word is written only as a whole, so a cut write leaves it alone
   always_comb begin
      logic [7:0] rx_byte;
      logic [7:0] load_byte;
      rx_byte         = link_shift_reg;
      load_byte       = icdac_pkg::BYTE_RST;
      state_next      = state_reg;
      bit_cnt_next    = bit_cnt_reg;
      byte_cnt_next   = byte_cnt_reg;
      rw_next         = rw_reg;
      hold_next       = hold_reg;
      tx_next         = tx_reg;
      sda_oe_next     = sda_oe_reg;
      input_word_next = input_word_reg;
      dac_next        = dac_reg;

      if (bus_start) begin
         state_next    = icdac_pkg::ST_ADDR;
         bit_cnt_next  = icdac_pkg::BIT_CNT_ZERO;
         byte_cnt_next = icdac_pkg::BYTE_ADDR;
         sda_oe_next   = 1'b0;
      end else if (bus_stop) begin
         state_next  = icdac_pkg::ST_IDLE;
         sda_oe_next = 1'b0;
      end else if (state_reg == icdac_pkg::ST_IDLE || state_reg == icdac_pkg::ST_IGNORE) begin
         sda_oe_next = 1'b0;
      end else if (scl_rise) begin
         bit_cnt_next = 4'(bit_cnt_reg + icdac_pkg::BIT_CNT_ONE);
      end else if (scl_fall) begin
         if (bit_cnt_reg == icdac_pkg::BIT_CNT_BYTE) begin
            unique case (state_reg)
               icdac_pkg::ST_ADDR: begin
                  if (rx_byte[icdac_pkg::ADDR_TOP_MSB:icdac_pkg::ADDR_TOP_LSB]
                      == icdac_pkg::SLAVE_ADDR_TOP) begin
                     sda_oe_next = 1'b1;
                     rw_next     = rx_byte[icdac_pkg::DIR_BIT];
                  end else begin
                     state_next = icdac_pkg::ST_IGNORE;
                  end
               end
               icdac_pkg::ST_RECV: begin
                  sda_oe_next = 1'b1;
                  if (byte_cnt_reg == icdac_pkg::BYTE_HIGH) begin
                     hold_next = rx_byte;
                  end else begin
                     input_word_next = {hold_reg, rx_byte};
                     dac_next        = word_to_dac({hold_reg, rx_byte});
                  end
               end
               icdac_pkg::ST_SEND: begin
                  sda_oe_next = (byte_cnt_reg == icdac_pkg::BYTE_LOW);
               end
               default: begin
                  sda_oe_next = 1'b0;
               end
            endcase
         end else if (bit_cnt_reg == icdac_pkg::BIT_CNT_ACK) begin
            // Ninth clock over: release the line, unless a read byte follows, and move to the next byte
            bit_cnt_next  = icdac_pkg::BIT_CNT_ZERO;
            byte_cnt_next = 2'(byte_cnt_reg + icdac_pkg::BYTE_ONE);
            sda_oe_next   = 1'b0;
            if (byte_cnt_reg == icdac_pkg::BYTE_LOW) begin
               state_next = icdac_pkg::ST_IGNORE;
               if (state_reg == icdac_pkg::ST_SEND) begin
                  input_word_next = icdac_pkg::INPUT_WORD_RST;
               end
            end else if (state_reg == icdac_pkg::ST_RECV) begin
               state_next = icdac_pkg::ST_RECV;
            end else if (state_reg == icdac_pkg::ST_ADDR && !rw_reg) begin
               state_next = icdac_pkg::ST_RECV;
            end else begin
               state_next  = icdac_pkg::ST_SEND;
               // Top bit of the next read byte goes out now, the rest on later falls
               load_byte   = word_byte(input_word_reg,
                                       2'(byte_cnt_reg + icdac_pkg::BYTE_ONE));
               sda_oe_next = ~load_byte[7];
               tx_next     = {load_byte[6:0], 1'b0};
            end
         end else if (state_reg == icdac_pkg::ST_SEND) begin
            sda_oe_next = ~tx_reg[7];
            tx_next     = {tx_reg[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         state_reg      <= icdac_pkg::ST_IDLE;
         bit_cnt_reg    <= icdac_pkg::BIT_CNT_ZERO;
         byte_cnt_reg   <= icdac_pkg::BYTE_ADDR;
         rw_reg         <= 1'b0;
         hold_reg       <= icdac_pkg::BYTE_RST;
         tx_reg         <= icdac_pkg::BYTE_RST;
         sda_oe_reg     <= 1'b0;
         input_word_reg <= icdac_pkg::INPUT_WORD_RST;
         dac_reg        <= icdac_pkg::DAC_RST;
      end else begin
         state_reg      <= state_next;
         bit_cnt_reg    <= bit_cnt_next;
         byte_cnt_reg   <= byte_cnt_next;
         rw_reg         <= rw_next;
         hold_reg       <= hold_next;
         tx_reg         <= tx_next;
         sda_oe_reg     <= sda_oe_next;
         input_word_reg <= input_word_next;
         dac_reg        <= dac_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-down pin: low sets the flops at once, release passes two flops
   logic pin_pd_meta_reg;
   logic pin_pd_meta_next;
   logic pin_pd_sync_reg;
   logic pin_pd_sync_next;

   always_comb begin
      pin_pd_meta_next = 1'b0;
      pin_pd_sync_next = pin_pd_meta_reg;
   end

   // A release close to a clock edge would otherwise reach the output flop raw
   always_ff @(posedge SYS_CLK or negedge POWER_DOWN_CONTROL_N) begin
      if (!POWER_DOWN_CONTROL_N) begin
         pin_pd_meta_reg <= 1'b1;
         pin_pd_sync_reg <= 1'b1;
      end else begin
         pin_pd_meta_reg <= pin_pd_meta_next;
         pin_pd_sync_reg <= pin_pd_sync_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-down output: pin low sets it without any clock
   always_comb begin
      pd_next = (RESETN & dac_next.power_down) | pin_pd_sync_reg;
   end

   always_ff @(posedge SYS_CLK or negedge POWER_DOWN_CONTROL_N) begin
      if (!POWER_DOWN_CONTROL_N) begin
         pd_reg <= 1'b1;
      end else begin
         pd_reg <= pd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_comb begin
      SDA_OUT        = 1'b0;
      SDA_OE         = sda_oe_reg;
      DAC_CODE       = dac_reg.code;
      DAC_POWER_DOWN = pd_reg;
      INPUT_WORD     = input_word_reg;
   end

endmodule : icdac_top

// ### icdac_props.sv
`timescale 1ns/1ps
module icdac_props (
   input wire logic        SYS_CLK,
   input wire logic        RESETN,
   input wire logic        SCL_CLK,
   input wire logic        SDA_IN,
   input wire logic        SDA_OUT,
   input wire logic        SDA_OE,
   input wire logic        POWER_DOWN_CONTROL_N,
   input wire logic [9:0]  DAC_CODE,
   input wire logic        DAC_POWER_DOWN,
   input wire logic [15:0] INPUT_WORD
);
   default clocking dc @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESETN);
   ////////////////////////////////////
   sequence scl_settled_high;
      SCL_CLK && $past(SCL_CLK, 4);
   endsequence
   sequence word_loaded;
      $changed(INPUT_WORD) && INPUT_WORD != 16'h0000 && POWER_DOWN_CONTROL_N;
   endsequence
   ////////////////////////////////////
   rst_clear_a: assert property (disable iff (1'b0) !RESETN |=> INPUT_WORD == 16'h0000
      && DAC_CODE == 10'h000 && !SDA_OE) else $error("reset not cleared");
   idle_release_a: assert property ($rose(RESETN) |-> !SDA_OE [*4])
      else $error("bus driven after reset");
   code_map_a: assert property ($changed(DAC_CODE) |-> $changed(INPUT_WORD)
      && DAC_CODE == INPUT_WORD[13:4]) else $error("code not from word");
   pin_pd_a: assert property (!POWER_DOWN_CONTROL_N |-> DAC_POWER_DOWN)
      else $error("pin power-down lost");
   soft_pd_a: assert property (word_loaded |-> ##[0:1] DAC_POWER_DOWN == INPUT_WORD[15])
      else $error("soft power-down wrong");
   oe_stable_a: assert property (scl_settled_high |-> $stable(SDA_OE))
      else $error("SDA moved, SCL high");
   oe_low_phase_a: assert property ($changed(SDA_OE) |-> !SCL_CLK && !$past(SCL_CLK, 2))
      else $error("SDA driven off low phase");
   word_edge_a: assert property ($changed(INPUT_WORD) |-> !SCL_CLK)
      else $error("word moved, SCL high");
endmodule : icdac_props
bind icdac_top icdac_props icdac_props_inst (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
   .SCL_CLK(SCL_CLK), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .POWER_DOWN_CONTROL_N(POWER_DOWN_CONTROL_N), .DAC_CODE(DAC_CODE),
   .DAC_POWER_DOWN(DAC_POWER_DOWN), .INPUT_WORD(INPUT_WORD));

// ### icdac_mst.sv
`timescale 1ns/1ps
module icdac_mst (
   input  wire logic lclk,
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   // One phase is three link clocks, beyond the device sync delay
   task automatic step(input logic lo, input logic c);
      sda_low = lo;
      scl     = c;
      repeat (3) @(posedge lclk);
   endtask : step
   task automatic start_c();
      step(1'b0, scl);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask : start_c
   task automatic stop_c();
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask : stop_c
   task automatic xbit(input logic b, output logic r);
      step(~b, 1'b0);
      step(~b, 1'b1);
      r = sda;
      step(~b, 1'b0);
   endtask : xbit
   task automatic xbyte(input logic [7:0] tx, input logic nin, output logic [7:0] rx,
                        output logic ninr);
      for (int i = 7; i >= 0; i--) xbit(tx[i], rx[i]);
      xbit(nin, ninr);
   endtask : xbyte
endmodule : icdac_mst

// ### icdac_top_tb_top.sv
`timescale 1ns/1ps
module icdac_top_tb_top;
   logic        sys_clk, link_clk, resetn, pd_n, scl, m_low, sda, sda_out, sda_oe, dac_pd;
   logic [9:0]  dac_code;
   logic [15:0] in_word;
   logic [15:0] rd;
   logic [31:0] rng;
   int          err_total, checked, m_word, m_code, m_pd;
   assign sda = ~(m_low | (sda_oe & ~sda_out));
   icdac_top icdac_top_inst (.SYS_CLK(sys_clk), .RESETN(resetn), .SCL_CLK(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .POWER_DOWN_CONTROL_N(pd_n), .DAC_CODE(dac_code),
      .DAC_POWER_DOWN(dac_pd), .INPUT_WORD(in_word));
   icdac_mst icdac_mst_inst (.lclk(link_clk), .scl(scl), .sda_low(m_low), .sda(sda));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7.3;
      forever #15 link_clk = ~link_clk;
   end
   ////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic chk_all();
      @(negedge sys_clk);
      chk(in_word, m_word[15:0], "word");
      chk({6'h00, dac_code}, m_code[15:0], "code");
      chk({15'h0000, dac_pd}, {15'h0000, m_pd[0] | ~pd_n}, "pd");
   endtask : chk_all
   task automatic xfer(input logic [7:0] a, input logic [15:0] w, input int n, input logic fin);
      logic [7:0] rx;
      logic       ak;
      logic       hit;
      hit = a[7:3] == 5'h03;
      rd  = 16'h0000;
      icdac_mst_inst.start_c();
      icdac_mst_inst.xbyte(a, 1'b1, rx, ak);
      chk({15'h0000, ak}, {15'h0000, ~hit}, "addr ack");
      for (int i = 0; i < n; i++) begin
         icdac_mst_inst.xbyte(a[0] ? 8'hff : (i == 0 ? w[15:8] : w[7:0]), ~(a[0] && i == 0),
                              rx, ak);
         chk({15'h0000, ak}, {15'h0000, ~(hit && i < 2)}, "data ack");
         rd = {rd[7:0], rx};
      end
      if (fin) icdac_mst_inst.stop_c();
      if (hit && n == 2 && a[0]) begin
         chk(rd, m_word[15:0], "read");
         m_word = 0;
      end else if (hit && n >= 2) begin
         m_word = w;
         m_code = w[13:4];
         m_pd   = w[15];
      end
      chk_all();
   endtask : xfer
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   ////////////////////////////////////
   initial begin
      #400_000;
      err_total++;
      conclude();
   end
   initial begin
      resetn = 1'b0;
      pd_n   = 1'b1;
      rng    = 32'h0000_0001;
      {err_total, checked, m_word, m_code, m_pd} = '0;
      repeat (6) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk_all();
      for (int k = 0; k < 8; k++) begin
         rng = xs(rng);
         xfer({5'h03, k[2:0]}, rng[15:0], 2, k[1]);
      end
      xfer(8'h10, 16'h1234, 2, 1'b1);
      xfer(8'h38, 16'h5678, 2, 1'b1);
      xfer(8'h1c, 16'hbff0, 3, 1'b1);
      xfer(8'h18, 16'h4321, 1, 1'b1);
      xfer(8'h1e, 16'h6543, 1, 1'b0);
      xfer(8'h1a, 16'h0000, 0, 1'b1);
      pd_n = 1'b0;
      chk_all();
      xfer(8'h18, 16'h03f0, 2, 1'b1);
      pd_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk_all();
      resetn = 1'b0;
      repeat (6) @(negedge sys_clk);
      resetn = 1'b1;
      {m_word, m_code, m_pd} = '0;
      chk_all();
      xfer(8'h18, 16'h8010, 2, 1'b1);
      conclude();
   end
endmodule : icdac_top_tb_top
